// ---- hw/drsp_gate_dt.sv ----
`timescale 1ns/10ps
// gate command pair with break-before-make dead-time
module drsp_gate_dt #(
  parameter int DEAD = 5
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic hs_req,   // wanted high-side state
  input  wire logic ls_req,   // wanted low-side state
  output logic      hs_q,
  output logic      ls_q
);
  logic [15:0] dead_q;  // cycles left with both gates off

  // ------------------------------------------------------------
  // a switch of side always passes through both-off for DEAD+1 cycles
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      hs_q   <= 1'b0;
      ls_q   <= 1'b0;
      dead_q <= 16'h0000;
    end else if (hs_q && !hs_req || ls_q && !ls_req) begin
      // turn off at once, then wait
      hs_q   <= hs_q & hs_req;
      ls_q   <= ls_q & ls_req;
      dead_q <= 16'(DEAD);
    end else if (dead_q != 16'h0000) begin
      dead_q <= dead_q - 16'h0001;
    end else if (!hs_q && !ls_q) begin
      // never both on: high side has priority if both asked
      hs_q <= hs_req;
      ls_q <= ls_req & ~hs_req;
    end
  end

  AST_NO_SHOOT: assert property (@(posedge clk) disable iff (srst)
    !(hs_q && ls_q)) else $error("both gates on");
  AST_DEAD_GAP: assert property (@(posedge clk) disable iff (srst)
    $fell(hs_q) |-> !ls_q [*2]) else $error("low side on inside dead-time");
endmodule

// ---- hw/drsp_sync2.sv ----
`timescale 1ns/10ps
// two-flop synchroniser, one per input bit
module drsp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;  // first stage, read only by the second

  // ------------------------------------------------------------
  // two stages
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// ---- hw/drsp_top.sv ----
`timescale 1ns/10ps
module drsp_top #(
  parameter bit VARIANT_B = 1'b0,              // 1: five-volt regulator on in standby
  parameter int SS_CYCLES = drsp_pkg::SS_CYC,  // soft-start length
  parameter int UV_CYCLES = drsp_pkg::UV_CYC,  // undervoltage blanking
  parameter int OV_CYCLES = drsp_pkg::OV_CYC   // overvoltage filter
) (
  input  wire logic       clk,
  input  wire logic       srst,               // input-supply power-on reset
  input  wire logic [1:0] en_rise_hi,         // enable above 1.6 V, per rail
  input  wire logic [1:0] en_fall_lo,         // enable below 0.4 V, per rail
  input  wire logic [1:0] pwm_req,            // on-time request per rail
  input  wire logic [1:0] out_pg_ok,          // output above 88 %
  input  wire logic [1:0] out_under20,        // output 20 % below nominal
  input  wire logic [1:0] out_over13,         // output 13 % above nominal
  input  wire logic [1:0] out_uv52,           // output below 52 %
  input  wire logic [1:0] out_still_high,     // output not yet discharged
  input  wire logic       reg5_low,           // five-volt regulator under 3.9 V
  input  wire logic       reg3_low,           // three-volt regulator under 2.5 V
  input  wire logic       reg_overcurrent,    // regulator current limit
  input  wire logic       over_temp,          // die above 150 C
  output logic      [1:0] high_side_gate_cmd,
  output logic      [1:0] low_side_gate_cmd,
  output logic      [1:0] discharge_on,       // output discharge switch
  output logic      [1:0] ss_active,          // soft-start running
  output logic      [15:0] ss_level [2],      // soft-start reference ramp
  output logic            power_good_out_o,   // open-drain data, always 0
  output logic            power_good_out_oe,  // high while pulled low
  output logic            five_volt_regulator,
  output logic            three_volt_regulator,
  output logic            pump_clock_out
);
  // ------------------------------------------------------------
  // synchronised inputs
  // ------------------------------------------------------------
  localparam int NS = 16;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] syn;
  assign raw_in = {en_rise_hi, en_fall_lo, pwm_req, out_pg_ok, out_under20,
                   out_over13, out_uv52, out_still_high};
  drsp_sync2 #(.W(NS)) u_sync (
    .clk  (clk),
    .srst (srst),
    .din  (raw_in),
    .dout (syn)
  );
  logic [1:0] s_rise, s_fall, s_pwm, s_pg, s_u20, s_o13, s_uv, s_hi;
  assign {s_rise, s_fall, s_pwm, s_pg, s_u20, s_o13, s_uv, s_hi} = syn;

  logic [3:0] flag_meta_q;  // first stage for the chip-level flags
  logic [3:0] flag_q;       // {over_temp, overcurrent, reg5_low, reg3_low}
  always_ff @(posedge clk) begin
    if (srst) begin
      flag_meta_q <= 4'h0;
      flag_q      <= 4'h0;
    end else begin
      flag_meta_q <= {over_temp, reg_overcurrent, reg5_low, reg3_low};
      flag_q      <= flag_meta_q;
    end
  end

  // ------------------------------------------------------------
  // chip-level conditions
  // ------------------------------------------------------------
  logic thermal_q;  // thermal shutdown, left only by supply reset
  always_ff @(posedge clk) begin
    if (srst) begin
      thermal_q <= 1'b0;
    end else if (flag_q[3]) begin
      thermal_q <= 1'b1;
    end
  end
  logic lockout;   // both regulators below their levels, not latched
  logic reg_fault; // regulator overcurrent or lockout
  assign lockout   = flag_q[1] & flag_q[0];
  assign reg_fault = lockout | flag_q[2];

  // ------------------------------------------------------------
  // pump clock divider, running only with the first rail on
  // ------------------------------------------------------------
  logic [15:0] pump_cnt_q;
  logic        pump_q;
  logic [1:0]  en_on_q;  // hysteretic enable state per rail
  always_ff @(posedge clk) begin
    if (srst || !en_on_q[0] || thermal_q) begin
      pump_cnt_q <= 16'h0000;
      pump_q     <= 1'b0;
    end else if (pump_cnt_q == 16'(drsp_pkg::PUMP_HALF - 1)) begin
      pump_cnt_q <= 16'h0000;
      pump_q     <= ~pump_q;
    end else begin
      pump_cnt_q <= pump_cnt_q + 16'h0001;
    end
  end
  assign pump_clock_out = pump_q;

  // ------------------------------------------------------------
  // per-rail sequencing
  // ------------------------------------------------------------
  logic [1:0] rail_run;  // rail in its run state, read by power-good
  for (genvar r = 0; r < 2; r++) begin : g_rail
    drsp_pkg::drsp_state_e st_q;
    logic [31:0] ss_cnt_q;   // soft-start progress
    logic [31:0] uv_cnt_q;   // undervoltage blanking left
    logic [31:0] ov_cnt_q;   // overvoltage persistence
    logic [5:0]  duty_q;     // duty frame position
    logic        en_prev_q;
    logic        hs_req;
    logic        ls_req;
    logic        en_rise;

    // enable hysteresis: on at the rising level, off at the falling level
    always_ff @(posedge clk) begin
      if (srst) begin
        en_on_q[r] <= 1'b0;
      end else if (s_rise[r]) begin
        en_on_q[r] <= 1'b1;
      end else if (s_fall[r]) begin
        en_on_q[r] <= 1'b0;
      end
    end
    always_ff @(posedge clk) begin
      if (srst) begin
        en_prev_q <= 1'b0;
      end else begin
        en_prev_q <= en_on_q[r];
      end
    end
    assign en_rise = en_on_q[r] & ~en_prev_q;
    assign rail_run[r] = (st_q == drsp_pkg::DRSP_RUN);

    // overvoltage filter: the flag must stand OV_CYCLES in a row
    always_ff @(posedge clk) begin
      if (srst || !s_o13[r]) begin
        ov_cnt_q <= 32'h0;
      end else if (ov_cnt_q < 32'(OV_CYCLES)) begin
        ov_cnt_q <= ov_cnt_q + 32'h1;
      end
    end

    // undervoltage blanking after every enable rise
    always_ff @(posedge clk) begin
      if (srst || en_rise) begin
        uv_cnt_q <= 32'(UV_CYCLES);
      end else if (uv_cnt_q != 32'h0) begin
        uv_cnt_q <= uv_cnt_q - 32'h1;
      end
    end

    // rail state machine; overvoltage and undervoltage faults latch until the enable drops
    always_ff @(posedge clk) begin
      if (srst || thermal_q) begin
        st_q     <= drsp_pkg::DRSP_OFF;
        ss_cnt_q <= 32'h0;
      end else if (!en_on_q[r]) begin
        st_q     <= drsp_pkg::DRSP_OFF;
        ss_cnt_q <= 32'h0;
      end else begin
        case (st_q)
          drsp_pkg::DRSP_OFF: begin
            // lockout holds the rail off without latching
            if (!reg_fault) begin
              st_q <= drsp_pkg::DRSP_SOFT;
            end
          end
          drsp_pkg::DRSP_SOFT, drsp_pkg::DRSP_RUN: begin
            if (ov_cnt_q >= 32'(OV_CYCLES)) begin
              st_q <= drsp_pkg::DRSP_OVF;
            end else if (s_uv[r] && uv_cnt_q == 32'h0) begin
              st_q <= drsp_pkg::DRSP_UVF;
            end else if (reg_fault) begin
              st_q     <= drsp_pkg::DRSP_OFF;
              ss_cnt_q <= 32'h0;
            end else if (st_q == drsp_pkg::DRSP_SOFT) begin
              if (ss_cnt_q >= 32'(SS_CYCLES - 1)) begin
                st_q <= drsp_pkg::DRSP_RUN;
              end else begin
                ss_cnt_q <= ss_cnt_q + 32'h1;
              end
            end
          end
          drsp_pkg::DRSP_OVF: st_q <= drsp_pkg::DRSP_OVF;
          drsp_pkg::DRSP_UVF: st_q <= drsp_pkg::DRSP_UVF;
          default: st_q <= drsp_pkg::DRSP_OFF;
        endcase
      end
    end

    // duty frame used only to cap on-time while ramping
    always_ff @(posedge clk) begin
      if (srst || st_q != drsp_pkg::DRSP_SOFT) begin
        duty_q <= 6'h00;
      end else begin
        duty_q <= duty_q + 6'h01;
      end
    end

    // gate requests by state
    always_comb begin
      hs_req = 1'b0;
      ls_req = 1'b0;
      case (st_q)
        drsp_pkg::DRSP_SOFT: begin
          // high side only in the first part of each frame
          hs_req = s_pwm[r] && (duty_q < 6'(drsp_pkg::DUTY_LIMIT));
          ls_req = !hs_req;
        end
        drsp_pkg::DRSP_RUN: begin
          hs_req = s_pwm[r];
          ls_req = !s_pwm[r];
        end
        drsp_pkg::DRSP_OVF: ls_req = 1'b1;
        drsp_pkg::DRSP_UVF: ls_req = 1'b0;
        default: ls_req = 1'b0;
      endcase
    end

    drsp_gate_dt #(.DEAD(drsp_pkg::DEAD_CYC)) u_gate (
      .clk    (clk),
      .srst   (srst),
      .hs_req (hs_req),
      .ls_req (ls_req),
      .hs_q   (high_side_gate_cmd[r]),
      .ls_q   (low_side_gate_cmd[r])
    );

    // discharge switch and soft-start outputs
    always_ff @(posedge clk) begin
      if (srst) begin
        discharge_on[r] <= 1'b0;
        ss_active[r]    <= 1'b0;
        ss_level[r]     <= 16'h0000;
      end else begin
        discharge_on[r] <= !thermal_q && (!en_on_q[r] || st_q == drsp_pkg::DRSP_UVF
                           || (st_q == drsp_pkg::DRSP_OFF && s_hi[r]));
        ss_active[r]    <= (st_q == drsp_pkg::DRSP_SOFT);
        // widened product: the full-length count times ffff overflows 32 bits
        ss_level[r]     <= 16'((48'(ss_cnt_q) * 48'h00ffff) / 48'(SS_CYCLES));
      end
    end

    AST_OV_FORCE: assert property (@(posedge clk) disable iff (srst)
      st_q == drsp_pkg::DRSP_OVF |-> ##[1:20] low_side_gate_cmd[r])
      else $error("overvoltage low side not forced");
    AST_UV_GATES: assert property (@(posedge clk) disable iff (srst)
      st_q == drsp_pkg::DRSP_UVF |-> ##2 !high_side_gate_cmd[r] && !low_side_gate_cmd[r])
      else $error("undervoltage gates not low");
    AST_UV_BLANK: assert property (@(posedge clk) disable iff (srst)
      en_rise |=> (st_q != drsp_pkg::DRSP_UVF) [*8])
      else $error("undervoltage taken during blanking");
    AST_OV_LATCH: assert property (@(posedge clk) disable iff (srst || thermal_q)
      st_q == drsp_pkg::DRSP_OVF && en_on_q[r] |=> st_q == drsp_pkg::DRSP_OVF)
      else $error("overvoltage latch lost");
  end

  // ------------------------------------------------------------
  // power-good and regulator enables
  // ------------------------------------------------------------
  logic pg_ok;
  logic any_en;
  assign any_en = en_on_q[0] | en_on_q[1];
  always_comb begin
    pg_ok = !thermal_q;
    for (int i = 0; i < 2; i++) begin
      // needs run state, above 88 %, and neither under nor over
      // the enable itself counts too: the state lags its drop by one cycle
      pg_ok = pg_ok && en_on_q[i] && rail_run[i] && s_pg[i] && !s_u20[i]
              && !s_o13[i];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      power_good_out_oe    <= 1'b1;
      five_volt_regulator  <= 1'b0;
      three_volt_regulator <= 1'b0;
    end else begin
      power_good_out_oe    <= !pg_ok;
      three_volt_regulator <= !thermal_q;
      five_volt_regulator  <= !thermal_q && (VARIANT_B || any_en
                              || reg_fault);
    end
  end
  assign power_good_out_o = 1'b0;

  AST_PG_STANDBY: assert property (@(posedge clk) disable iff (srst)
    !any_en |=> power_good_out_oe) else $error("power-good released in standby");
  AST_THERM_OFF: assert property (@(posedge clk) disable iff (srst)
    thermal_q |-> ##2 !five_volt_regulator && !three_volt_regulator && !pump_clock_out)
    else $error("circuits on in thermal shutdown");
  AST_PUMP_OFF: assert property (@(posedge clk) disable iff (srst)
    !en_on_q[0] |=> !pump_clock_out) else $error("pump clock without first rail");
  AST_REG5_EN: assert property (@(posedge clk) disable iff (srst || thermal_q)
    any_en |=> five_volt_regulator) else $error("five-volt regulator off while enabled");
endmodule

// ---- inc/drsp_pkg.sv ----
package drsp_pkg;
  // ----------------------------------------------------------------
  // timing figures and derived cycle counts at the 125 MHz clock
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 125000000;
  localparam int SS_TIME_US   = 900;   // soft-start ramp, 0.9 ms
  localparam int UV_BLANK_US  = 1300;  // undervoltage blanking, 1.3 ms
  localparam int OV_FILT_NS   = 1000;  // overvoltage filter, 1 us
  localparam int DEAD_TIME_NS = 40;    // gate dead-time
  // least times round up, none below one cycle
  localparam int SS_CYC    = (SS_TIME_US * (CLK_HZ / 1000000));
  localparam int UV_CYC    = (UV_BLANK_US * (CLK_HZ / 1000000));
  localparam int OV_CYC    = (OV_FILT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int DEAD_CYC  = (DEAD_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // pump clock half period for 260 kHz
  localparam int PUMP_HZ   = 260000;
  localparam int PUMP_HALF = CLK_HZ / (2 * PUMP_HZ);
  // soft-start duty limit: on-window out of a 64-cycle frame while ramping
  localparam int DUTY_FRAME = 64;
  localparam int DUTY_LIMIT = 32;

  // ----------------------------------------------------------------
  // per-rail state machine, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    DRSP_OFF   = 5'h01,
    DRSP_SOFT  = 5'h02,
    DRSP_RUN   = 5'h04,
    DRSP_OVF   = 5'h08,
    DRSP_UVF   = 5'h10
  } drsp_state_e;
endpackage

// ---- testbench/drsp_rail_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// behavioural output stage of both rails
// ----------------------------------------------------------------
// gate on-time charges the output, low side or discharge switch drains it;
// the level is capped at nominal so overshoot only comes from f_ov
module drsp_rail_model (
  input  wire logic       clk,
  input  wire logic [1:0] hs,
  input  wire logic [1:0] ls,
  input  wire logic [1:0] dis,
  input  wire logic [1:0] f_ov,        // forced overshoot
  input  wire logic [1:0] f_uv,        // forced collapse
  output logic      [1:0] pg_ok,
  output logic      [1:0] under20,
  output logic      [1:0] over13,
  output logic      [1:0] uv52,
  output logic      [1:0] still_high
);
  logic [7:0] lvl [2];                 // output level, c8 is nominal
  initial lvl = '{8'h00, 8'h00};
  // slow ramp so the pg threshold is crossed well after soft-start begins
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (hs[i] && lvl[i] < 8'hc8) lvl[i] <= lvl[i] + 8'h02;
      else if ((ls[i] || dis[i]) && lvl[i] != 8'h00) lvl[i] <= lvl[i] - 8'h01;
    end
  end
  // comparator flags as the analog front end would give them
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pg_ok[i]      = !f_uv[i] && lvl[i] >= 8'hb0;
      under20[i]    = f_uv[i] || lvl[i] < 8'ha0;
      over13[i]     = f_ov[i];
      uv52[i]       = f_uv[i] || lvl[i] < 8'h68;
      still_high[i] = lvl[i] != 8'h00;
    end
  end
endmodule

// ---- testbench/drsp_tb_top.sv ----
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_count++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module drsp_tb_top;
  // ----------------------------------------------------------------
  // stimulus, design and far-side model
  // ----------------------------------------------------------------
  localparam int SS = 200;             // shortened soft-start
  logic clk, srst, reg5_low, reg3_low, reg_overcurrent, over_temp;
  logic [1:0] en_rise_hi, en_fall_lo, pwm_req, f_ov, f_uv;
  logic [1:0] pg_ok, under20, over13, uv52, still_high;
  logic [1:0] high_side_gate_cmd, low_side_gate_cmd, discharge_on, ss_active;
  logic [15:0] ss_level [2];
  logic pg_o, pg_oe, five_v, three_v, pump;
  int err_count, n_compared;
  int lo_cnt [2];                      // cycles the high side has been low
  logic [1:0] ls_p;

  drsp_top #(.VARIANT_B(1'b0), .SS_CYCLES(SS), .UV_CYCLES(300), .OV_CYCLES(125)) dut (
    .clk(clk), .srst(srst), .en_rise_hi(en_rise_hi), .en_fall_lo(en_fall_lo),
    .pwm_req(pwm_req), .out_pg_ok(pg_ok), .out_under20(under20), .out_over13(over13),
    .out_uv52(uv52), .out_still_high(still_high), .reg5_low(reg5_low),
    .reg3_low(reg3_low), .reg_overcurrent(reg_overcurrent), .over_temp(over_temp),
    .high_side_gate_cmd(high_side_gate_cmd), .low_side_gate_cmd(low_side_gate_cmd),
    .discharge_on(discharge_on), .ss_active(ss_active), .ss_level(ss_level),
    .power_good_out_o(pg_o), .power_good_out_oe(pg_oe), .five_volt_regulator(five_v),
    .three_volt_regulator(three_v), .pump_clock_out(pump));

  drsp_rail_model model (.clk(clk), .hs(high_side_gate_cmd), .ls(low_side_gate_cmd),
    .dis(discharge_on), .f_ov(f_ov), .f_uv(f_uv), .pg_ok(pg_ok), .under20(under20),
    .over13(over13), .uv52(uv52), .still_high(still_high));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // low side may only rise after the high side has rested a dead-time
  always @(negedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (low_side_gate_cmd[i] === 1'b1 && ls_p[i] === 1'b0)
        `CHK("dead_time", 1'b1, lo_cnt[i] >= drsp_pkg::DEAD_CYC)
      lo_cnt[i] = (high_side_gate_cmd[i] === 1'b0) ? lo_cnt[i] + 1 : 0;
    end
    ls_p = low_side_gate_cmd;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_en(input logic [1:0] on);
    @(posedge clk);
    en_rise_hi <= on;
    en_fall_lo <= ~on;
    cyc(1);
  endtask
  // bounded wait for the pin to be released
  task automatic wait_pg(input int n);
    int k;
    k = 0;
    while (pg_oe !== 1'b0 && k < n) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_standby;
    `CHK("hs", 2'h0, high_side_gate_cmd);
    `CHK("pg_oe", 1'b1, pg_oe);
    `CHK("pg_o", 1'b0, pg_o);
    `CHK("five", 1'b0, five_v);
    `CHK("three", 1'b1, three_v);
    `CHK("pump", 1'b0, pump);
  endtask
  // first rail alone: ramp length, duty limit, pump clock, pg held
  task automatic t_first_on;
    int hs_n, tog;
    logic p0;
    hs_n = 0;
    tog = 0;
    set_en(2'b01);
    p0 = pump;
    for (int i = 0; i < 520; i++) begin
      cyc(1);
      if (i >= 8 && i < 72) hs_n += int'(high_side_gate_cmd[0]);
      if (pump !== p0) tog++;
      p0 = pump;
      if (i == 8) `CHK("ss", 2'h1, ss_active);
      if (i == 8) `CHK("five", 1'b1, five_v);
      if (i == 8) `CHK("pg_ss", 1'b1, pg_oe);
      if (i == SS - 20) `CHK("ss_on", 1'b1, ss_active[0]);
      if (i == SS + 20) `CHK("ss_off", 1'b0, ss_active[0]);
    end
    `CHK("duty", 1'b1, hs_n <= drsp_pkg::DUTY_LIMIT);
    `CHK("pump_tog", 1'b1, tog >= 2);
    `CHK("pg_one", 1'b1, pg_oe);
  endtask
  task automatic t_both;
    set_en(2'b11);
    wait_pg(900);
    `CHK("pg_rel", 1'b0, pg_oe);
  endtask
  task automatic t_ov;
    @(posedge clk) f_ov <= 2'b01;
    cyc(40);
    `CHK("pg_ov", 1'b1, pg_oe);
    @(posedge clk) f_ov <= 2'b00;
    cyc(10);
    wait_pg(50);
    `CHK("glitch", 1'b0, pg_oe);
    @(posedge clk) f_ov <= 2'b01;
    cyc(160);
    `CHK("ov_ls", 1'b1, low_side_gate_cmd[0]);
    `CHK("ov_hs", 1'b0, high_side_gate_cmd[0]);
    @(posedge clk) f_ov <= 2'b00;
    cyc(50);
    `CHK("ov_latch", 1'b1, low_side_gate_cmd[0]);
    `CHK("ov_regs", 2'h3, {five_v, three_v});
    set_en(2'b10);
    cyc(6);
    `CHK("dis_off", 1'b1, discharge_on[0]);
    set_en(2'b11);
    cyc(8);
    `CHK("ov_clr", 1'b1, ss_active[0]);
    wait_pg(900);
    `CHK("ov_up", 1'b0, pg_oe);
  endtask
  task automatic t_uv;
    set_en(2'b01);
    cyc(20);
    set_en(2'b11);
    @(posedge clk) f_uv <= 2'b10;
    cyc(100);
    `CHK("uv_blank", 1'b0, discharge_on[1]);
    @(posedge clk) f_uv <= 2'b00;
    cyc(250);
    @(posedge clk) f_uv <= 2'b10;
    cyc(10);
    `CHK("uv_gates", 2'h0, {high_side_gate_cmd[1], low_side_gate_cmd[1]});
    `CHK("uv_dis", 1'b1, discharge_on[1]);
    `CHK("uv_regs", 2'h3, {five_v, three_v});
    @(posedge clk) f_uv <= 2'b00;
    cyc(20);
    `CHK("uv_latch", 1'b0, high_side_gate_cmd[1]);
    set_en(2'b01);
    cyc(6);
    set_en(2'b11);
    wait_pg(900);
    `CHK("uv_clr", 1'b0, pg_oe);
  endtask
  task automatic t_lockout;
    @(posedge clk) reg5_low <= 1'b1;
    cyc(10);
    `CHK("one_low", 1'b0, pg_oe);
    @(posedge clk) reg3_low <= 1'b1;
    cyc(10);
    `CHK("lock_hs", 2'h0, high_side_gate_cmd);
    @(posedge clk) {reg5_low, reg3_low} <= 2'h0;
    cyc(10);
    `CHK("lock_rst", 2'h3, ss_active);
    wait_pg(900);
    `CHK("lock_up", 1'b0, pg_oe);
    @(posedge clk) reg_overcurrent <= 1'b1;
    cyc(10);
    `CHK("oc_hs", 2'h0, high_side_gate_cmd);
    `CHK("oc_regs", 2'h3, {five_v, three_v});
    @(posedge clk) reg_overcurrent <= 1'b0;
    wait_pg(900);
    `CHK("oc_up", 1'b0, pg_oe);
  endtask
  task automatic t_thermal;
    @(posedge clk) over_temp <= 1'b1;
    cyc(10);
    `CHK("ot_all", 5'h00, {high_side_gate_cmd, low_side_gate_cmd, pump});
    @(posedge clk) over_temp <= 1'b0;
    cyc(20);
    `CHK("ot_regs", 2'h0, {five_v, three_v});
    @(posedge clk) srst <= 1'b1;
    cyc(3);
    `CHK("por_pg", 1'b1, pg_oe);
    @(posedge clk) srst <= 1'b0;
    wait_pg(900);
    `CHK("por_up", 1'b0, pg_oe);
  endtask

  // watchdog: whole run needs well under 10000 cycles
  initial begin
    #500000;
    err_count++;
    report_and_stop;
  end

  initial begin
    {srst, reg5_low, reg3_low, reg_overcurrent, over_temp} = 5'h10;
    {en_rise_hi, f_ov, f_uv} = 6'h00;
    en_fall_lo = 2'h3;
    pwm_req = 2'h3;
    lo_cnt = '{100, 100};
    ls_p = 2'h0;
    err_count = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    cyc(4);
    t_standby;
    t_first_on;
    t_both;
    t_ov;
    t_uv;
    t_lockout;
    t_thermal;
    report_and_stop;
  end
endmodule
